// ==== logic/smhp_counter.sv ====
/*
  One timer counter: control word, load value, read back, square-wave output.
  Assumes tick_in is a one-cycle pulse of the counter's input clock.
*/
`timescale 1ns/1ps
module smhp_counter
  import smhp_pkg::*;
(
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  input  wire logic                ce_in,
  input  wire logic                tick_in,
  input  wire logic                cw_wr_in,
  input  wire logic [5:0]          cw_in,
  input  wire logic                data_wr_in,
  input  wire logic [DATA_W-1:0]   data_in,
  input  wire logic                rd_in,
  output logic      [DATA_W-1:0]   read_byte_out,
  output logic                     out_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [1:0]         rw_reg;
  logic [COUNT_W-1:0] reload_reg;
  logic [COUNT_W-1:0] count_reg;
  logic [COUNT_W-1:0] latch_reg;
  logic               latched_reg;
  logic               wr_hi_reg;
  logic               rd_hi_reg;
  logic               armed_reg;
  logic               out_reg;
  logic [COUNT_W-1:0] new_value;
  logic               load_done;
  logic [COUNT_W-1:0] shown;

  always_comb begin
    new_value = reload_reg;
    load_done = 1'b0;
    case (rw_reg)
      RW_LSB: begin
        new_value = {8'h00, data_in};
        load_done = data_wr_in;
      end
      RW_MSB: begin
        new_value = {data_in, 8'h00};
        load_done = data_wr_in;
      end
      default: begin
        new_value = wr_hi_reg ? {data_in, reload_reg[7:0]} : {reload_reg[15:8], data_in};
        load_done = data_wr_in & wr_hi_reg;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Host side: mode and load value
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rw_reg     <= CW_RESET[5:4];
      reload_reg <= '0;
      wr_hi_reg  <= 1'b0;
    end else if (ce_in) begin
      if (cw_wr_in && cw_in[5:4] != RW_LATCH) begin
        rw_reg    <= cw_in[5:4];
        wr_hi_reg <= 1'b0;
      end else if (data_wr_in) begin
        reload_reg <= new_value;
        if (rw_reg == RW_BOTH)
          wr_hi_reg <= ~wr_hi_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Counting runs on ticks alone, never on the select
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      count_reg <= '0;
      armed_reg <= 1'b0;
      out_reg   <= 1'b1;
    end else if (ce_in) begin
      if (cw_wr_in && cw_in[5:4] != RW_LATCH) begin
        armed_reg <= 1'b0;
        out_reg   <= 1'b1;
      end else if (load_done) begin
        count_reg <= new_value;
        armed_reg <= 1'b1;
      end else if (tick_in && armed_reg) begin
        if (count_reg == COUNT_ONE) begin
          count_reg <= reload_reg;
          out_reg   <= ~out_reg;
        end else begin
          count_reg <= count_reg - COUNT_ONE;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read back, with latch so a two-byte read is coherent
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      latch_reg   <= '0;
      latched_reg <= 1'b0;
      rd_hi_reg   <= 1'b0;
    end else if (ce_in) begin
      if (cw_wr_in && cw_in[5:4] == RW_LATCH && !latched_reg) begin
        latch_reg   <= count_reg;
        latched_reg <= 1'b1;
      end else if (cw_wr_in) begin
        rd_hi_reg <= 1'b0;
      end else if (rd_in) begin
        if (rw_reg == RW_BOTH)
          rd_hi_reg <= ~rd_hi_reg;
        if (rw_reg != RW_BOTH || rd_hi_reg)
          latched_reg <= 1'b0;
      end
    end
  end

  assign shown         = latched_reg ? latch_reg : count_reg;
  assign read_byte_out = (rw_reg == RW_MSB || (rw_reg == RW_BOTH && rd_hi_reg)) ?
                         shown[15:8] : shown[7:0];
  assign out_out       = out_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_count_down;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && tick_in && armed_reg && !cw_wr_in && !data_wr_in && count_reg != COUNT_ONE
      |=> count_reg == $past(count_reg) - COUNT_ONE;
  endproperty
  a_count_down: assert property (p_count_down) else $error("Counter did not step");

  property p_load;
    @(posedge clk_in) disable iff (rst_in)
    ce_in && !cw_wr_in && data_wr_in && rw_reg == RW_LSB
      |=> count_reg == {8'h00, $past(data_in)} && armed_reg;
  endproperty
  a_load: assert property (p_load) else $error("Load value not taken");

endmodule // smhp_counter

// ==== logic/smhp_host_port.sv ====
/*
  Host port of the serial module: strobe decode, serial controller registers,
  timer counters, clock prescaler, interrupt jumpers and option lines.
  Assumes host pins are synchronous to CLK_IN and a serializer outside.
*/
//
// Overview of operation
// - Reset idles serial controller until new words
// - Low address bit picks register
// - Both address bits pick counter or control
// - Serial read returns received data or status
// - Timer read returns addressed counter value
// - Serial write takes data or control word
// - Timer write takes mode or load value
// - Deselected serial controller floats, ignores strobes
// - Timer select gates access, counters keep running
// - Eight active-high bidirectional data lines
// - Interrupt lines jumpered to timer or ready
// - Four-bit counter divides base clock
// - Serial clock follows timer programming
// - Option lines are configurable general purpose
`timescale 1ns/1ps
module smhp_host_port (
  input  wire logic                        CLK_IN,
  input  wire logic                        RST_IN,
  input  wire logic                        CE_IN,
  input  wire logic                        BASE_TICK_IN,
  input  wire logic                        ADDR_BIT_LO_IN,
  input  wire logic                        ADDR_BIT_HI_IN,
  input  wire logic                        SERIAL_SELECT_N_IN,
  input  wire logic                        TIMER_SELECT_N_IN,
  input  wire logic                        RD_N_IN,
  input  wire logic                        WR_N_IN,
  input  wire logic [smhp_pkg::DATA_W-1:0] HOST_DATA_BUS_IN,
  output logic      [smhp_pkg::DATA_W-1:0] HOST_DATA_BUS_OUT,
  output logic                             HOST_DATA_BUS_OE_OUT,
  input  wire logic [1:0]                  IRQ_A_SOURCE_IN,
  input  wire logic [1:0]                  IRQ_B_SOURCE_IN,
  output logic                             IRQ_LINE_A_OUT,
  output logic                             IRQ_LINE_B_OUT,
  input  wire logic                        TX_DONE_IN,
  input  wire logic                        RX_VALID_IN,
  input  wire logic [smhp_pkg::DATA_W-1:0] RX_DATA_IN,
  output logic      [smhp_pkg::DATA_W-1:0] TX_DATA_OUT,
  output logic                             TX_LOAD_OUT,
  output logic                             TX_ENABLE_OUT,
  output logic                             RX_ENABLE_OUT,
  output logic                             SYNC_MODE_OUT,
  output logic                             TRANSMIT_READY_FLAG_OUT,
  output logic                             SERIAL_CLK_OUT,
  input  wire logic [1:0]                  OPTION_DIR_IN,
  input  wire logic [1:0]                  OPTION_DRIVE_IN,
  input  wire logic                        OPTION_LINE_A_IN,
  input  wire logic                        OPTION_LINE_B_IN,
  output logic                             OPTION_LINE_A_OUT,
  output logic                             OPTION_LINE_B_OUT,
  output logic                             OPTION_LINE_A_OE_OUT,
  output logic                             OPTION_LINE_B_OE_OUT,
  output logic      [1:0]                  OPTION_SAMPLE_OUT
);
  import smhp_pkg::*;

  // ----------------------------------------------------------------
  // Strobe decode
  // ----------------------------------------------------------------
  logic               rd_n_d_reg;
  logic               wr_n_d_reg;
  logic               one_sel;
  logic               ser_rd;
  logic               ser_wr;
  logic               tmr_rd;
  logic               tmr_wr;
  logic [1:0]         tmr_addr;

  // Both selects at once is a host fault; the access is dropped
  assign one_sel  = SERIAL_SELECT_N_IN ^ TIMER_SELECT_N_IN;
  assign ser_rd   = CE_IN & ~RD_N_IN & rd_n_d_reg & ~SERIAL_SELECT_N_IN & one_sel;
  assign ser_wr   = CE_IN & ~WR_N_IN & wr_n_d_reg & ~SERIAL_SELECT_N_IN & one_sel;
  assign tmr_rd   = CE_IN & ~RD_N_IN & rd_n_d_reg & ~TIMER_SELECT_N_IN & one_sel;
  assign tmr_wr   = CE_IN & ~WR_N_IN & wr_n_d_reg & ~TIMER_SELECT_N_IN & one_sel;
  assign tmr_addr = {ADDR_BIT_HI_IN, ADDR_BIT_LO_IN};

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      rd_n_d_reg <= 1'b1;
      wr_n_d_reg <= 1'b1;
    end else if (CE_IN) begin
      rd_n_d_reg <= RD_N_IN;
      wr_n_d_reg <= WR_N_IN;
    end
  end

  // ----------------------------------------------------------------
  // Clock prescaler
  // ----------------------------------------------------------------
  logic [PRESCALE_W-1:0] pre_cnt_reg;
  logic                  tick_fast;
  logic                  tick_slow;

  always_ff @(posedge CLK_IN) begin
    if (RST_IN)
      pre_cnt_reg <= '0;
    else if (CE_IN && BASE_TICK_IN)
      pre_cnt_reg <= pre_cnt_reg + PRESCALE_STEP;
  end

  // Divide by 2 and by 16 of the base clock
  assign tick_fast = BASE_TICK_IN & pre_cnt_reg[0];
  assign tick_slow = BASE_TICK_IN & (pre_cnt_reg == PRESCALE_LAST);

  // ----------------------------------------------------------------
  // Timer counters
  // ----------------------------------------------------------------
  logic [NUM_COUNTERS-1:0] tmr_out;
  logic [DATA_W-1:0]       tmr_byte [NUM_COUNTERS];
  logic [NUM_COUNTERS-1:0] cnt_tick;

  // Counter 2 feeds the serial clock, so it runs on the fast tick
  assign cnt_tick = {tick_fast, tick_slow, tick_fast};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_COUNTERS; gi++) begin : g_cnt
      smhp_counter u_cnt (
        .clk_in        (CLK_IN),
        .rst_in        (RST_IN),
        .ce_in         (CE_IN),
        .tick_in       (cnt_tick[gi]),
        .cw_wr_in      (tmr_wr && tmr_addr == TMR_ADDR_CTRL &&
                        HOST_DATA_BUS_IN[CW_SEL_HI:CW_SEL_LO] == 2'(gi)),
        .cw_in         (HOST_DATA_BUS_IN[5:0]),
        .data_wr_in    (tmr_wr && tmr_addr == 2'(gi)),
        .data_in       (HOST_DATA_BUS_IN),
        .rd_in         (tmr_rd && tmr_addr == 2'(gi)),
        .read_byte_out (tmr_byte[gi]),
        .out_out       (tmr_out[gi])
      );
    end
  endgenerate

  assign SERIAL_CLK_OUT = tmr_out[2];

  // ----------------------------------------------------------------
  // Serial controller registers
  // ----------------------------------------------------------------
  smhp_ser_state_t state_reg;
  logic            tx_full_reg;
  logic            rx_ready_reg;
  logic [DATA_W-1:0] rx_data_reg;
  logic [DATA_W-1:0] status_vec;
  logic            ser_ctrl_wr;
  logic            ser_data_wr;

  assign ser_ctrl_wr = ser_wr & ADDR_BIT_LO_IN;
  assign ser_data_wr = ser_wr & ~ADDR_BIT_LO_IN;

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      state_reg     <= ST_EXPECT_MODE;
      SYNC_MODE_OUT <= 1'b0;
      TX_ENABLE_OUT <= 1'b0;
      RX_ENABLE_OUT <= 1'b0;
    end else if (ser_ctrl_wr) begin
      case (state_reg)
        ST_EXPECT_MODE: begin
          SYNC_MODE_OUT <= HOST_DATA_BUS_IN[MODE_BAUD_HI:MODE_BAUD_LO] == MODE_SYNC;
          state_reg     <= ST_EXPECT_CMD;
        end
        default: begin
          if (HOST_DATA_BUS_IN[CMD_INT_RESET]) begin
            state_reg     <= ST_EXPECT_MODE;
            TX_ENABLE_OUT <= 1'b0;
            RX_ENABLE_OUT <= 1'b0;
          end else begin
            state_reg     <= ST_RUNNING;
            TX_ENABLE_OUT <= HOST_DATA_BUS_IN[CMD_TX_EN];
            RX_ENABLE_OUT <= HOST_DATA_BUS_IN[CMD_RX_EN];
          end
        end
      endcase
    end
  end

  // Transmit holding byte; a write in the done cycle stays full
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      tx_full_reg <= 1'b0;
      TX_LOAD_OUT <= 1'b0;
      TX_DATA_OUT <= '0;
    end else if (CE_IN) begin
      TX_LOAD_OUT <= 1'b0;
      if (ser_data_wr && state_reg == ST_RUNNING) begin
        TX_DATA_OUT <= HOST_DATA_BUS_IN;
        TX_LOAD_OUT <= 1'b1;
        tx_full_reg <= 1'b1;
      end else if (TX_DONE_IN) begin
        tx_full_reg <= 1'b0;
      end
    end
  end

  // Receive flag: new byte wins over the clearing read
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      rx_ready_reg <= 1'b0;
      rx_data_reg  <= '0;
    end else if (CE_IN) begin
      if (RX_VALID_IN && RX_ENABLE_OUT) begin
        rx_ready_reg <= 1'b1;
        rx_data_reg  <= RX_DATA_IN;
      end else if (ser_rd && !ADDR_BIT_LO_IN) begin
        rx_ready_reg <= 1'b0;
      end
    end
  end

  assign TRANSMIT_READY_FLAG_OUT = TX_ENABLE_OUT & ~tx_full_reg & (state_reg == ST_RUNNING);
  assign status_vec = {5'h00, ~tx_full_reg, rx_ready_reg, TRANSMIT_READY_FLAG_OUT};

  // ----------------------------------------------------------------
  // Read data and bus drive
  // ----------------------------------------------------------------
  logic hold_ser_reg;
  logic hold_tmr_reg;

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      HOST_DATA_BUS_OUT <= '0;
    end else if (ser_rd) begin
      HOST_DATA_BUS_OUT <= ADDR_BIT_LO_IN ? status_vec : rx_data_reg;
    end else if (tmr_rd) begin
      HOST_DATA_BUS_OUT <= (tmr_addr == TMR_ADDR_CTRL) ? 8'h00 : tmr_byte[tmr_addr];
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      hold_ser_reg <= 1'b0;
      hold_tmr_reg <= 1'b0;
    end else if (CE_IN) begin
      hold_ser_reg <= ser_rd | (hold_ser_reg & ~RD_N_IN);
      hold_tmr_reg <= tmr_rd | (hold_tmr_reg & ~RD_N_IN);
    end
  end

  // Drive only while the strobe and the captured select still hold
  assign HOST_DATA_BUS_OE_OUT = ~RD_N_IN & ~RST_IN &
         ((hold_ser_reg & ~SERIAL_SELECT_N_IN) | (hold_tmr_reg & ~TIMER_SELECT_N_IN));

  // ----------------------------------------------------------------
  // Interrupt jumpers and option lines
  // ----------------------------------------------------------------
  function automatic logic irq_pick(input logic [1:0] src, input logic o0,
                                    input logic o1, input logic rdy);
    irq_pick = (src == IRQ_SRC_OUT0) ? o0 : (src == IRQ_SRC_OUT1) ? o1 :
               (src == IRQ_SRC_TRANSMIT_READY_FLAG) ? rdy : 1'b0;
  endfunction

  assign IRQ_LINE_A_OUT = irq_pick(IRQ_A_SOURCE_IN, tmr_out[0], tmr_out[1],
                                   TRANSMIT_READY_FLAG_OUT);
  assign IRQ_LINE_B_OUT = irq_pick(IRQ_B_SOURCE_IN, tmr_out[0], tmr_out[1],
                                   TRANSMIT_READY_FLAG_OUT);

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      OPTION_SAMPLE_OUT <= '0;
      OPTION_LINE_A_OUT <= 1'b0;
      OPTION_LINE_B_OUT <= 1'b0;
    end else if (CE_IN) begin
      OPTION_SAMPLE_OUT <= {OPTION_LINE_B_IN, OPTION_LINE_A_IN};
      OPTION_LINE_A_OUT <= OPTION_DRIVE_IN[0];
      OPTION_LINE_B_OUT <= OPTION_DRIVE_IN[1];
    end
  end

  assign OPTION_LINE_A_OE_OUT = OPTION_DIR_IN[0] & ~RST_IN;
  assign OPTION_LINE_B_OE_OUT = OPTION_DIR_IN[1] & ~RST_IN;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_reset_idle;
    @(posedge CLK_IN) RST_IN |=> state_reg == ST_EXPECT_MODE && !TX_ENABLE_OUT;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("No idle after reset");

  property p_idle_stays;
    @(posedge CLK_IN) disable iff (RST_IN)
    state_reg == ST_EXPECT_MODE && !ser_ctrl_wr |=> state_reg == ST_EXPECT_MODE;
  endproperty
  a_idle_stays: assert property (p_idle_stays) else $error("Left idle without words");

  property p_float;
    @(posedge CLK_IN) disable iff (RST_IN)
    SERIAL_SELECT_N_IN && TIMER_SELECT_N_IN |-> !HOST_DATA_BUS_OE_OUT;
  endproperty
  a_float: assert property (p_float) else $error("Bus driven while deselected");

  property p_ignore;
    @(posedge CLK_IN) disable iff (RST_IN)
    SERIAL_SELECT_N_IN && state_reg == ST_RUNNING |=> !TX_LOAD_OUT && state_reg == ST_RUNNING;
  endproperty
  a_ignore: assert property (p_ignore) else $error("Strobe acted while deselected");

  property p_status_read;
    @(posedge CLK_IN) disable iff (RST_IN)
    ser_rd && ADDR_BIT_LO_IN |=> HOST_DATA_BUS_OUT == $past(status_vec);
  endproperty
  a_status_read: assert property (p_status_read) else $error("Status not returned");

  property p_tx_load;
    @(posedge CLK_IN) disable iff (RST_IN)
    ser_data_wr && state_reg == ST_RUNNING
      |=> TX_LOAD_OUT && TX_DATA_OUT == $past(HOST_DATA_BUS_IN) ##1 !TX_LOAD_OUT;
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("Transmit byte not taken");

  property p_irq_ready;
    @(posedge CLK_IN) disable iff (RST_IN)
    IRQ_A_SOURCE_IN == IRQ_SRC_TRANSMIT_READY_FLAG |-> IRQ_LINE_A_OUT == TRANSMIT_READY_FLAG_OUT;
  endproperty
  a_irq_ready: assert property (p_irq_ready) else $error("Interrupt source wrong");

  property p_prescale;
    @(posedge CLK_IN) disable iff (RST_IN)
    CE_IN && BASE_TICK_IN |=> pre_cnt_reg == $past(pre_cnt_reg) + PRESCALE_STEP;
  endproperty
  a_prescale: assert property (p_prescale) else $error("Prescaler did not step");

endmodule // smhp_host_port

// ==== logic/smhp_pkg.sv ====
/*
  Shared constants and types for the serial module host port.
  Assumes a single 40 MHz clock and a host that keeps its own write spacing.
*/
package smhp_pkg;

  // ----------------------------------------------------------------
  // Clock and host spacing
  // ----------------------------------------------------------------
  localparam int CLK_HZ             = 40000000;
  localparam int CLK_PERIOD_PS      = 1000000000 / (CLK_HZ / 1000);
  // Least spacing of control writes the host keeps, in ns
  localparam int T_CTRL_INIT_NS     = 1920;
  localparam int T_CTRL_ASYNC_NS    = 2560;
  localparam int T_CTRL_SYNC_NS     = 5120;
  localparam int CYC_CTRL_INIT      = (T_CTRL_INIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CYC_CTRL_ASYNC     = (T_CTRL_ASYNC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CYC_CTRL_SYNC      = (T_CTRL_SYNC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // Widths and prescaler
  // ----------------------------------------------------------------
  localparam int DATA_W             = 8;
  localparam int COUNT_W            = 16;
  localparam int PRESCALE_W         = 4;
  localparam logic [3:0] PRESCALE_STEP = 4'h1;
  localparam logic [3:0] PRESCALE_LAST = 4'hf;
  localparam int NUM_COUNTERS       = 3;

  // ----------------------------------------------------------------
  // Interrupt source jumpers
  // ----------------------------------------------------------------
  localparam logic [1:0] IRQ_SRC_OUT0  = 2'h0;
  localparam logic [1:0] IRQ_SRC_OUT1  = 2'h1;
  localparam logic [1:0] IRQ_SRC_TRANSMIT_READY_FLAG = 2'h2;

  // ----------------------------------------------------------------
  // Timer addressing and control word fields
  // ----------------------------------------------------------------
  localparam logic [1:0] TMR_ADDR_CTRL = 2'h3;
  localparam int CW_SEL_HI          = 7;
  localparam int CW_SEL_LO          = 6;
  localparam int CW_RW_HI           = 5;
  localparam int CW_RW_LO           = 4;
  localparam logic [1:0] RW_LATCH   = 2'h0;
  localparam logic [1:0] RW_LSB     = 2'h1;
  localparam logic [1:0] RW_MSB     = 2'h2;
  localparam logic [1:0] RW_BOTH    = 2'h3;
  localparam logic [5:0] CW_RESET   = 6'h36;
  localparam logic [15:0] COUNT_ONE = 16'h0001;

  // ----------------------------------------------------------------
  // Serial controller words
  // ----------------------------------------------------------------
  localparam int MODE_BAUD_HI       = 1;
  localparam int MODE_BAUD_LO       = 0;
  localparam logic [1:0] MODE_SYNC  = 2'h0;
  localparam int CMD_TX_EN          = 0;
  localparam int CMD_RX_EN          = 2;
  localparam int CMD_INT_RESET      = 6;
  localparam int ST_TRANSMIT_READY_FLAG           = 0;
  localparam int ST_RXRDY           = 1;
  localparam int ST_TXEMPTY         = 2;

  typedef enum logic [2:0] {
    ST_EXPECT_MODE = 3'b001,
    ST_EXPECT_CMD  = 3'b010,
    ST_RUNNING     = 3'b100
  } smhp_ser_state_t;

endpackage

// ==== test/smhp_host_model.sv ====
/* Host bus model: selects, address, strobes; owns the data wire.
   Assumes one access at a time, started from the bench. */
`timescale 1ns/1ps
module smhp_host_model (
  input  wire logic       clk_in,
  input  wire logic       dev_oe_in,
  input  wire logic [7:0] dev_data_in,
  output logic      [7:0] bus_out,
  output logic      [1:0] sel_n_out,
  output logic      [1:0] addr_out,
  output logic            rd_n_out,
  output logic            wr_n_out
);
  logic [7:0] hd;
  logic       drv;
  // Released wire shows the inverse byte, so stale data never passes
  assign bus_out = dev_oe_in ? dev_data_in : (drv ? hd : ~hd);
  initial begin
    {sel_n_out, addr_out, rd_n_out, wr_n_out, drv, hd} = {6'h33, 9'h000};
  end
  task automatic access(input logic rd, input logic [1:0] sel, input logic [1:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_in);
    sel_n_out <= sel;
    addr_out  <= a;
    hd        <= d;
    drv       <= ~rd;
    rd_n_out  <= ~rd;
    wr_n_out  <= rd;
    repeat (2) @(posedge clk_in);
    #1 q = bus_out;
    @(posedge clk_in);
    {sel_n_out, rd_n_out, wr_n_out, drv} <= 5'h1e;
  endtask
endmodule // smhp_host_model

// ==== test/testbench.sv ====
/* Self-checking bench for the serial module host port.
   Assumes the host model owns strobes and data wire. */
`timescale 1ns/1ps
module testbench;
  import smhp_pkg::*;
  logic       clk, rst, tick, txd, rxv, irqa_d, sclk_d;
  logic [7:0] rxd, q;
  logic [3:0] cnt;
  wire        oe, irqa, irqb, txl, txe, rxe, syn, rdy, sclk, rd_n, wr_n;
  wire  [1:0] sel_n, addr, ooe, oo, osmp;
  wire  [7:0] bus, dout, txdat;
  int         err_count, n_checks, n_loads, na, nc;
  smhp_host_model i_smhp_host_model (.clk_in(clk), .dev_oe_in(oe), .dev_data_in(dout),
    .bus_out(bus), .sel_n_out(sel_n), .addr_out(addr), .rd_n_out(rd_n), .wr_n_out(wr_n));
  smhp_host_port i_smhp_host_port (.CLK_IN(clk), .RST_IN(rst), .CE_IN(1'b1),
    .BASE_TICK_IN(tick), .ADDR_BIT_LO_IN(addr[0]), .ADDR_BIT_HI_IN(addr[1]),
    .SERIAL_SELECT_N_IN(sel_n[0]), .TIMER_SELECT_N_IN(sel_n[1]), .RD_N_IN(rd_n),
    .WR_N_IN(wr_n), .HOST_DATA_BUS_IN(bus), .HOST_DATA_BUS_OUT(dout),
    .HOST_DATA_BUS_OE_OUT(oe), .IRQ_A_SOURCE_IN(2'h0), .IRQ_B_SOURCE_IN(2'h2),
    .IRQ_LINE_A_OUT(irqa), .IRQ_LINE_B_OUT(irqb), .TX_DONE_IN(txd), .RX_VALID_IN(rxv),
    .RX_DATA_IN(rxd), .TX_DATA_OUT(txdat), .TX_LOAD_OUT(txl), .TX_ENABLE_OUT(txe),
    .RX_ENABLE_OUT(rxe), .SYNC_MODE_OUT(syn), .TRANSMIT_READY_FLAG_OUT(rdy),
    .SERIAL_CLK_OUT(sclk), .OPTION_DIR_IN(2'h1), .OPTION_DRIVE_IN(2'h2),
    .OPTION_LINE_A_IN(ooe[0] ? oo[0] : 1'b1), .OPTION_LINE_B_IN(ooe[1] ? oo[1] : 1'b1),
    .OPTION_LINE_A_OUT(oo[0]), .OPTION_LINE_B_OUT(oo[1]), .OPTION_LINE_A_OE_OUT(ooe[0]),
    .OPTION_LINE_B_OE_OUT(ooe[1]), .OPTION_SAMPLE_OUT(osmp));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Base tick every 16 cycles, near the generator rate
  always @(posedge clk) begin
    cnt <= cnt + 4'h1;
    tick <= (cnt == 4'hf);
    if (txl === 1'b1) n_loads <= n_loads + 1;
    irqa_d <= irqa;
    sclk_d <= sclk;
    if (irqa !== irqa_d) na <= na + 1;
    if (sclk !== sclk_d) nc <= nc + 1;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic t_serial();
    chk(8'({oe, txl, txe}), 8'h00);
    i_smhp_host_model.access(1'b0, 2'b10, 2'h0, 8'h11, q);
    chk(8'(n_loads), 8'h00);
    i_smhp_host_model.access(1'b0, 2'b10, 2'h1, 8'h4e, q);
    repeat (CYC_CTRL_INIT) @(posedge clk);
    i_smhp_host_model.access(1'b0, 2'b10, 2'h1, 8'h05, q);
    chk(8'({txe, rxe, syn}), 8'h06);
    i_smhp_host_model.access(1'b1, 2'b10, 2'h1, 8'h00, q);
    chk(8'(q[0]), 8'h01);
    i_smhp_host_model.access(1'b0, 2'b10, 2'h0, 8'ha5, q);
    chk(8'({n_loads[0], rdy, irqb}), 8'h04);
    chk(txdat, 8'ha5);
    {txd, rxv, rxd} <= 10'h33c;
    @(posedge clk);
    {txd, rxv} <= 2'h0;
    repeat (2) @(posedge clk);
    chk(8'({rdy, irqb}), 8'h03);
    i_smhp_host_model.access(1'b1, 2'b10, 2'h0, 8'h00, q);
    chk(q, 8'h3c);
    i_smhp_host_model.access(1'b1, 2'b10, 2'h1, 8'h00, q);
    chk(q, 8'h05);
  endtask
  task automatic t_desel();
    i_smhp_host_model.access(1'b1, 2'b11, 2'h0, 8'h5a, q);
    chk(q, 8'ha5);
    i_smhp_host_model.access(1'b1, 2'b00, 2'h1, 8'h5a, q);
    chk(q, 8'ha5);
    i_smhp_host_model.access(1'b0, 2'b11, 2'h0, 8'h77, q);
    chk(8'(n_loads), 8'h01);
  endtask
  // Internal reset, then a synchronous set-up with its wider spacing
  task automatic t_modes();
    repeat (CYC_CTRL_ASYNC) @(posedge clk);
    i_smhp_host_model.access(1'b0, 2'b10, 2'h1, 8'h40, q);
    chk(8'({txe, rxe, rdy}), 8'h00);
    repeat (CYC_CTRL_INIT) @(posedge clk);
    i_smhp_host_model.access(1'b0, 2'b10, 2'h1, 8'h00, q);
    repeat (CYC_CTRL_INIT) @(posedge clk);
    i_smhp_host_model.access(1'b0, 2'b10, 2'h1, 8'h01, q);
    chk(8'({txe, rxe, syn, rdy}), 8'h0b);
    repeat (CYC_CTRL_SYNC) @(posedge clk);
    i_smhp_host_model.access(1'b0, 2'b10, 2'h1, 8'h05, q);
    chk(8'({txe, rxe, syn}), 8'h07);
  endtask
  task automatic t_timer();
    i_smhp_host_model.access(1'b0, 2'b01, 2'h3, 8'h36, q);
    i_smhp_host_model.access(1'b0, 2'b01, 2'h0, 8'h04, q);
    i_smhp_host_model.access(1'b0, 2'b01, 2'h0, 8'h00, q);
    i_smhp_host_model.access(1'b0, 2'b01, 2'h3, 8'hb6, q);
    i_smhp_host_model.access(1'b0, 2'b01, 2'h2, 8'h03, q);
    i_smhp_host_model.access(1'b0, 2'b01, 2'h2, 8'h00, q);
    i_smhp_host_model.access(1'b1, 2'b01, 2'h3, 8'h00, q);
    chk(q, 8'h00);
    i_smhp_host_model.access(1'b1, 2'b01, 2'h0, 8'h00, q);
    chk(8'(q != 8'h00 && q <= 8'h04), 8'h01);
    i_smhp_host_model.access(1'b1, 2'b01, 2'h0, 8'h00, q);
    chk(q, 8'h00);
    i_smhp_host_model.access(1'b0, 2'b01, 2'h3, 8'h50, q);
    i_smhp_host_model.access(1'b0, 2'b01, 2'h1, 8'h09, q);
    i_smhp_host_model.access(1'b0, 2'b01, 2'h3, 8'h40, q);
    i_smhp_host_model.access(1'b1, 2'b01, 2'h1, 8'h00, q);
    chk(8'(q >= 8'h08 && q <= 8'h09), 8'h01);
    // Cleared off the edge so no pending count update overwrites it
    @(negedge clk) {na, nc} = 64'h0;
    repeat (600) @(posedge clk);
    chk(8'({na >= 3, nc >= 5}), 8'h03);
    chk(8'({ooe, oo, osmp}), 8'h1a);
  endtask
  initial begin
    {rst, tick, txd, rxv, rxd, cnt} = {4'h8, 12'h000};
    {err_count, n_checks, n_loads, na, nc} = 160'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_serial();
    t_desel();
    t_modes();
    t_timer();
    close_out();
  end
  initial begin
    #200000;
    err_count++;
    close_out();
  end
endmodule // testbench
